// ---- swq_segment_sequencer.sv ----
`timescale 1ns/1ps
module swq_segment_sequencer (
  input  wire logic                 clk_sys_in,
  input  wire logic                 srst_in,
  input  wire swq_pkg::swq_cmd_type cmd_in,
  input  wire logic [3:0]           own_chan_in,
  input  wire logic [3:0]           installed_chans_in,
  input  wire swq_pkg::swq_src_type source_in,
  input  wire logic                 start_in,
  output logic                      trig_out,
  output logic                      seg_active_out,
  output logic                      busy_out,
  output logic                      done_out,
  output logic                      cmd_error_out
);
  import swq_pkg::*;

  function automatic logic [26:0] min_ticks(input swq_src_type src);
    int ns;
    case (src)
      SRC_GEN_10V: ns = MIN_GEN10_NS;
      SRC_PM_10V:  ns = MIN_PM10_NS;
      SRC_40V:     ns = MIN_V40_NS;
      default:     ns = MIN_V40_NS;
    endcase
    // Segment floor of 20 ns also covers the first segment
    if (ns < MIN_SEG_NS) ns = MIN_SEG_NS;
    return 27'((ns + TICK_NS - 1) / TICK_NS);
  endfunction : min_ticks

  function automatic logic [15:0] seg_addr(input logic [8:0] s, input logic [6:0] g);
    return {s, g};
  endfunction : seg_addr

  logic [26:0]   dur_mem  [SEQ_MAX*SEG_MAX];
  logic          trig_mem [SEQ_MAX*SEG_MAX];
  logic [8:0]    list_seq_mem [LIST_DEPTH];
  logic [39:0]   list_rep_mem [LIST_DEPTH];
  logic [7:0]    dur_cnt_reg  [SEQ_MAX];
  logic [7:0]    trig_cnt_reg [SEQ_MAX];
  logic [8:0]    list_len_reg;
  logic [7:0]    words_reg;

  swq_state_type state_reg;
  logic [1:0]    prime_cnt_reg;
  logic          prime_reg;
  logic [8:0]    cur_seq_reg;
  logic [6:0]    cur_seg_reg;
  logic [8:0]    lp_reg;
  logic [39:0]   rep_reg;
  swq_pos_type   npos_next;
  swq_pos_type   npos_reg;
  logic [8:0]    lnx_seq_reg;
  logic [39:0]   lnx_rep_reg;
  logic [26:0]   dur_rd_reg;
  logic          trig_rd_reg;
  logic          expire;
  logic          adv;

  logic          chan_ok;
  logic          mine;
  logic          seq_ok;
  logic [8:0]    seq_ix;
  logic          words_ok;
  logic          is_dur;
  logic          is_trig;
  logic          is_list;
  logic          is_def;
  logic [7:0]    base_cnt;
  logic [8:0]    list_base;
  logic          val_ok;
  logic          wr_ok;
  logic          bad;
  logic [8:0]    lp_plus;

  // Command decode
  always_comb begin
    chan_ok = (cmd_in.chan >= 4'(CH_MIN)) && (cmd_in.chan <= 4'(CH_MAX)) &&
              (cmd_in.chan <= installed_chans_in);
    mine    = cmd_in.valid && chan_ok && (cmd_in.chan == own_chan_in);
    seq_ok  = (cmd_in.seq >= 10'(SEQ_MIN)) && (cmd_in.seq <= 10'(SEQ_MAX));
    seq_ix  = 9'(cmd_in.seq - 10'h001);
    words_ok = cmd_in.first || (words_reg < 8'(CMD_VALS_MAX));
    is_dur  = (cmd_in.op == OP_DEFINE_SEGMENT_DURATIONS) ||
              (cmd_in.op == OP_APPEND_SEGMENT_DURATIONS);
    is_trig = (cmd_in.op == OP_DEFINE_SEGMENT_TRIGGER_LEVELS) ||
              (cmd_in.op == OP_APPEND_SEGMENT_TRIGGER_LEVELS);
    is_list = (cmd_in.op == OP_DEFINE_PLAYBACK_LIST) ||
              (cmd_in.op == OP_APPEND_PLAYBACK_LIST);
    is_def  = (cmd_in.op == OP_DEFINE_SEGMENT_DURATIONS) ||
              (cmd_in.op == OP_DEFINE_SEGMENT_TRIGGER_LEVELS) ||
              (cmd_in.op == OP_DEFINE_PLAYBACK_LIST);
    // Define clears on its first value, so the rest append behind it
    base_cnt  = (is_def && cmd_in.first) ? 8'h00 :
                (is_dur ? dur_cnt_reg[seq_ix] : trig_cnt_reg[seq_ix]);
    list_base = (is_def && cmd_in.first) ? 9'h000 : list_len_reg;
    val_ok = 1'b0;
    if (is_dur) begin
      val_ok = seq_ok && (base_cnt < 8'(SEG_MAX)) &&
               (cmd_in.data[39:27] == 13'h0000) &&
               (cmd_in.data[26:0] >= min_ticks(source_in)) &&
               (cmd_in.data[26:0] <= 27'(DUR_MAX_TICKS));
    end else if (is_trig) begin
      val_ok = seq_ok && (base_cnt < 8'(SEG_MAX)) && (cmd_in.data[39:1] == 39'h0);
    end else if (is_list) begin
      // Undefined sequences are refused rather than played as empty
      val_ok = seq_ok && (list_base < 9'(LIST_DEPTH)) && (dur_cnt_reg[seq_ix] != 8'h00) &&
               (cmd_in.data >= LOOP_MIN) && (cmd_in.data <= LOOP_MAX);
    end
    wr_ok = mine && words_ok && val_ok && (state_reg == ST_IDLE);
    bad   = cmd_in.valid && (cmd_in.op != OP_NONE) && (!chan_ok || (mine && !wr_ok));
  end

  always_ff @(posedge clk_sys_in) begin
    if (srst_in) begin
      words_reg <= 8'h00;
    end else if (mine) begin
      words_reg <= cmd_in.first ? 8'h01 : words_reg + 8'h01;
    end
  end

  // Array contents carry no reset; counts gate every read
  always_ff @(posedge clk_sys_in) begin
    if (wr_ok && is_dur) begin
      dur_mem[seg_addr(seq_ix, base_cnt[6:0])] <= cmd_in.data[26:0];
    end
    if (wr_ok && is_trig) begin
      trig_mem[seg_addr(seq_ix, base_cnt[6:0])] <= cmd_in.data[0];
    end
    if (wr_ok && is_list) begin
      list_seq_mem[list_base[7:0]] <= seq_ix;
      list_rep_mem[list_base[7:0]] <= cmd_in.data;
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (srst_in) begin
      for (int i = 0; i < SEQ_MAX; i++) begin
        dur_cnt_reg[i]  <= 8'h00;
        trig_cnt_reg[i] <= 8'h00;
      end
      list_len_reg <= 9'h000;
    end else if (wr_ok) begin
      if (is_dur) dur_cnt_reg[seq_ix] <= base_cnt + 8'h01;
      if (is_trig) trig_cnt_reg[seq_ix] <= base_cnt + 8'h01;
      if (is_list) list_len_reg <= list_base + 9'h001;
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (srst_in) begin
      cmd_error_out <= 1'b0;
    end else begin
      cmd_error_out <= bad;
    end
  end

  // Next position is prefetched so each segment switches on the expiry edge
  always_comb begin
    lp_plus   = lp_reg + 9'h001;
    npos_next = '0;
    npos_next.seq = cur_seq_reg;
    npos_next.lp  = lp_reg;
    npos_next.rep = rep_reg;
    if (!prime_reg && ({1'b0, cur_seg_reg} + 8'h01 < dur_cnt_reg[cur_seq_reg])) begin
      npos_next.seg = cur_seg_reg + 7'h01;
    end else if (!prime_reg && (rep_reg > 40'h0000000001)) begin
      npos_next.seg = 7'h00;
      npos_next.rep = rep_reg - 40'h0000000001;
    end else begin
      npos_next.seg = 7'h00;
      npos_next.lp  = lp_plus;
      npos_next.seq = lnx_seq_reg;
      npos_next.rep = lnx_rep_reg;
      npos_next.fin = (lp_plus == list_len_reg);
    end
    npos_next.use_trig = {1'b0, npos_next.seg} < trig_cnt_reg[npos_next.seq];
  end

  always_ff @(posedge clk_sys_in) begin
    lnx_seq_reg <= list_seq_mem[lp_plus[7:0]];
    lnx_rep_reg <= list_rep_mem[lp_plus[7:0]];
    npos_reg    <= npos_next;
    dur_rd_reg  <= dur_mem[seg_addr(npos_reg.seq, npos_reg.seg)];
    trig_rd_reg <= trig_mem[seg_addr(npos_reg.seq, npos_reg.seg)];
  end

  assign adv = ((state_reg == ST_PRIME) && (prime_cnt_reg == 2'h0)) ||
               ((state_reg == ST_RUN) && expire);

  swq_seg_timer u_timer (
    .clk_sys_in (clk_sys_in),
    .srst_in    (srst_in),
    .load_in    (adv && !npos_reg.fin),
    .cycles_in  (28'(dur_rd_reg) * 28'(CYC_PER_TICK)),
    .stop_in    (1'b0),
    .expire_out (expire)
  );

  always_ff @(posedge clk_sys_in) begin
    if (srst_in) begin
      state_reg     <= ST_IDLE;
      prime_cnt_reg <= 2'h0;
      prime_reg     <= 1'b0;
      lp_reg        <= 9'h000;
      rep_reg       <= 40'h0000000000;
      cur_seq_reg   <= 9'h000;
      cur_seg_reg   <= 7'h00;
    end else begin
      case (state_reg)
        ST_IDLE: begin
          if (start_in) begin
            state_reg     <= ST_PRIME;
            prime_reg     <= 1'b1;
            lp_reg        <= 9'h1ff;
            prime_cnt_reg <= 2'(PRIME_WAIT);
          end
        end
        ST_PRIME: begin
          if (prime_cnt_reg != 2'h0) prime_cnt_reg <= prime_cnt_reg - 2'h1;
        end
        ST_RUN: begin
        end
        default: state_reg <= ST_IDLE;
      endcase
      if (adv) begin
        prime_reg <= 1'b0;
        if (npos_reg.fin) begin
          state_reg <= ST_IDLE;
        end else begin
          state_reg   <= ST_RUN;
          cur_seq_reg <= npos_reg.seq;
          cur_seg_reg <= npos_reg.seg;
          lp_reg      <= npos_reg.lp;
          rep_reg     <= npos_reg.rep;
        end
      end
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (srst_in) begin
      trig_out       <= 1'b0;
      seg_active_out <= 1'b0;
      busy_out       <= 1'b0;
      done_out       <= 1'b0;
    end else begin
      done_out <= adv && npos_reg.fin;
      busy_out <= (state_reg != ST_IDLE || start_in) && !(adv && npos_reg.fin);
      if (adv) begin
        seg_active_out <= !npos_reg.fin;
        // Idle level is low; not a documented level
        trig_out <= npos_reg.fin ? 1'b0 :
                    (npos_reg.use_trig ? trig_rd_reg : TRIG_DEFAULT);
      end
    end
  end
endmodule : swq_segment_sequencer

// ---- swq_pkg.sv ----
package swq_pkg;
  localparam int CLK_NS          = 5;
  localparam int TICK_NS         = 10;
  localparam int CYC_PER_TICK    = TICK_NS / CLK_NS;
  localparam int CH_MIN          = 1;
  localparam int CH_MAX          = 8;
  localparam int SEQ_MIN         = 1;
  localparam int SEQ_MAX         = 512;
  localparam int SEG_MAX         = 128;
  localparam int CMD_VALS_MAX    = 128;
  localparam int LIST_DEPTH      = 256;
  localparam int DUR_MAX_NS      = 1000000000;
  localparam int DUR_MAX_TICKS   = DUR_MAX_NS / TICK_NS;
  localparam int MIN_GEN10_NS    = 10;
  localparam int MIN_PM10_NS     = 20;
  localparam int MIN_V40_NS      = 50;
  localparam int MIN_SEG_NS      = 20;
  localparam int PRIME_WAIT      = 3;
  localparam logic [39:0] LOOP_MIN = 40'h0000000001;
  localparam logic [39:0] LOOP_MAX = 40'he8d4a51000;
  localparam logic        TRIG_DEFAULT = 1'b1;

  typedef enum logic [2:0] {
    OP_NONE                          = 3'h0,
    OP_DEFINE_SEGMENT_DURATIONS      = 3'h1,
    OP_APPEND_SEGMENT_DURATIONS      = 3'h2,
    OP_DEFINE_SEGMENT_TRIGGER_LEVELS = 3'h3,
    OP_APPEND_SEGMENT_TRIGGER_LEVELS = 3'h4,
    OP_DEFINE_PLAYBACK_LIST          = 3'h5,
    OP_APPEND_PLAYBACK_LIST          = 3'h6
  } swq_op_type;

  typedef enum logic [1:0] {
    SRC_GEN_10V = 2'h0,
    SRC_PM_10V  = 2'h1,
    SRC_40V     = 2'h2
  } swq_src_type;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'h0,
    ST_PRIME = 2'h1,
    ST_RUN   = 2'h2
  } swq_state_type;

  typedef struct packed {
    logic        valid;
    swq_op_type  op;
    logic        first;
    logic [3:0]  chan;
    logic [9:0]  seq;
    logic [39:0] data;
  } swq_cmd_type;

  typedef struct packed {
    logic        fin;
    logic        use_trig;
    logic [8:0]  seq;
    logic [6:0]  seg;
    logic [8:0]  lp;
    logic [39:0] rep;
  } swq_pos_type;
endpackage : swq_pkg

// ---- swq_seg_timer.sv ----
`timescale 1ns/1ps
module swq_seg_timer (
  input  wire logic        clk_sys_in,
  input  wire logic        srst_in,
  input  wire logic        load_in,
  input  wire logic [27:0] cycles_in,
  input  wire logic        stop_in,
  output logic             expire_out
);
  import swq_pkg::*;

  logic [27:0] cnt_reg;
  logic        run_reg;

  always_ff @(posedge clk_sys_in) begin
    if (srst_in) begin
      cnt_reg <= 28'h0000000;
      run_reg <= 1'b0;
    end else if (load_in) begin
      cnt_reg <= cycles_in - 28'h0000001;
      run_reg <= 1'b1;
    end else if (stop_in || (run_reg && cnt_reg == 28'h0000000)) begin
      run_reg <= 1'b0;
    end else if (run_reg) begin
      cnt_reg <= cnt_reg - 28'h0000001;
    end
  end

  // Fires in the last cycle so the next segment starts without a gap
  assign expire_out = run_reg && (cnt_reg == 28'h0000000);
endmodule : swq_seg_timer

// ---- swq_seq_props.sv ----
`timescale 1ns/1ps
module swq_seq_props
  import swq_pkg::*;
(
  input wire logic        clk_sys_in,
  input wire logic        srst_in,
  input wire swq_cmd_type cmd_in,
  input wire logic [3:0]  own_chan_in,
  input wire logic [3:0]  installed_chans_in,
  input wire swq_src_type source_in,
  input wire logic        start_in,
  input wire logic        trig_out,
  input wire logic        seg_active_out,
  input wire logic        busy_out,
  input wire logic        done_out,
  input wire logic        cmd_error_out
);
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (srst_in);
  logic cmd_v, mine, dur_op, trig_op, list_op;
  assign cmd_v   = cmd_in.valid && cmd_in.op != OP_NONE;
  assign mine    = cmd_v && cmd_in.chan == own_chan_in;
  assign dur_op  = cmd_in.op inside {OP_DEFINE_SEGMENT_DURATIONS, OP_APPEND_SEGMENT_DURATIONS};
  assign trig_op = cmd_in.op inside {OP_DEFINE_SEGMENT_TRIGGER_LEVELS,
                                     OP_APPEND_SEGMENT_TRIGGER_LEVELS};
  assign list_op = cmd_in.op inside {OP_DEFINE_PLAYBACK_LIST, OP_APPEND_PLAYBACK_LIST};
  chan_refuse_a: assert property (
    cmd_v && (cmd_in.chan == 4'h0 || cmd_in.chan > 4'h8 || cmd_in.chan > installed_chans_in)
    |=> cmd_error_out) else $error("bad channel not refused");
  seq_range_a: assert property (
    mine && (cmd_in.seq == 10'h000 || cmd_in.seq > 10'h200) |=> cmd_error_out)
    else $error("bad sequence id not refused");
  dur_floor_a: assert property (
    mine && dur_op && cmd_in.data < ((source_in == SRC_40V) ? 40'h5 : 40'h2) |=> cmd_error_out)
    else $error("short duration not refused");
  dur_ceiling_a: assert property (
    mine && dur_op && cmd_in.data > 40'h0005f5e100 |=> cmd_error_out)
    else $error("long duration not refused");
  trig_value_a: assert property (
    mine && trig_op && cmd_in.data > 40'h1 |=> cmd_error_out)
    else $error("bad trigger value not refused");
  rep_range_a: assert property (
    mine && list_op && (cmd_in.data == 40'h0 || cmd_in.data > LOOP_MAX) |=> cmd_error_out)
    else $error("bad repeat count not refused");
  start_busy_a: assert property (
    start_in && !busy_out && !done_out |=> busy_out) else $error("start not taken");
  first_seg_a: assert property (
    $rose(busy_out) |-> !seg_active_out [*4] ##1 (seg_active_out || done_out))
    else $error("first segment mistimed");
  done_pulse_a: assert property (
    done_out |-> !busy_out && $past(busy_out) ##1 !done_out) else $error("done pulse wrong");
  trig_in_seg_a: assert property (
    trig_out |-> seg_active_out && busy_out) else $error("trigger high outside segment");
  seg_min_a: assert property (
    $rose(seg_active_out) |-> seg_active_out [*4]) else $error("segment too short");
  done_c: cover property (done_out);
  err_c: cover property (cmd_error_out);
  low_c: cover property (seg_active_out && !trig_out);
endmodule : swq_seq_props

// ---- swq_load_model.sv ----
`timescale 1ns/1ps
module swq_load_model (
  input  wire logic        clk_sys_in,
  input  wire logic        clr_in,
  input  wire logic        trig_in,
  input  wire logic        seg_active_in,
  output logic      [15:0] act_cnt_out,
  output logic      [15:0] hi_cnt_out
);
  // Passive load, tallies only; it never drives anything back
  // Levels not modelled, so every segment join counts as seamless
  always_ff @(posedge clk_sys_in) begin
    if (clr_in) begin
      act_cnt_out <= 16'h0000;
      hi_cnt_out  <= 16'h0000;
    end else if (seg_active_in) begin
      act_cnt_out <= act_cnt_out + 16'h0001;
      hi_cnt_out  <= hi_cnt_out + {15'h0000, trig_in};
    end
  end
endmodule : swq_load_model

// ---- tb_top.sv ----
`timescale 1ns/1ps
module tb_top;
  import swq_pkg::*;
  logic        clk_sys_in = 1'b0;
  logic        srst_in    = 1'b1;
  logic        start_in   = 1'b0;
  logic        clr        = 1'b0;
  swq_cmd_type cmd_in     = '0;
  swq_src_type source_in  = SRC_PM_10V;
  logic        trig_out, seg_active_out, busy_out, done_out, cmd_error_out;
  logic [15:0] act_cnt, hi_cnt;
  int          err_count = 0, total_checks = 0, cyc = 0;
  initial forever #2.5 clk_sys_in = ~clk_sys_in;
  swq_segment_sequencer uut (.clk_sys_in(clk_sys_in), .srst_in(srst_in), .cmd_in(cmd_in),
    .own_chan_in(4'h1), .installed_chans_in(4'h4), .source_in(source_in),
    .start_in(start_in), .trig_out(trig_out), .seg_active_out(seg_active_out),
    .busy_out(busy_out), .done_out(done_out), .cmd_error_out(cmd_error_out));
  swq_load_model load (.clk_sys_in(clk_sys_in), .clr_in(clr), .trig_in(trig_out),
    .seg_active_in(seg_active_out), .act_cnt_out(act_cnt), .hi_cnt_out(hi_cnt));
  task automatic complete_run();
    $display("checks %0d errors %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : complete_run
  task automatic chk(input logic [39:0] seen, input logic [39:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("BAD t=%0t seen %0h expected %0h", $time, seen, exp);
    end
  endtask : chk
  // One word; the error pulse stands only in the cycle after the taking edge
  task automatic try(input swq_op_type op, input logic f, input logic [3:0] ch,
                     input logic [9:0] sq, input logic [39:0] d, input logic e);
    cmd_in = '{1'b1, op, f, ch, sq, d};
    @(posedge clk_sys_in) #1;
    chk(cmd_error_out, e);
    cmd_in.valid = 1'b0;
    @(posedge clk_sys_in) #1;
  endtask : try
  // A second start at cycle 3 lands while busy and must change nothing
  task automatic play(input int n_exp, input int act, input int hi);
    int n;
    n = 0;
    start_in = 1'b1;
    clr = 1'b1;
    do begin
      @(posedge clk_sys_in) #1;
      n++;
      clr = 1'b0;
      start_in = (n == 3);
    end while (done_out !== 1'b1 && n < 400);
    chk(n, n_exp);
    chk(act_cnt, act);
    chk(hi_cnt, hi);
  endtask : play
  task automatic refusals();
    try(OP_DEFINE_SEGMENT_DURATIONS, 1, 4'h0, 10'h1, 40'h2, 1);
    try(OP_DEFINE_SEGMENT_DURATIONS, 1, 4'h9, 10'h1, 40'h2, 1);
    try(OP_DEFINE_SEGMENT_DURATIONS, 1, 4'h5, 10'h1, 40'h2, 1);
    try(OP_DEFINE_SEGMENT_DURATIONS, 1, 4'h2, 10'h1, 40'h2, 0);
    try(OP_DEFINE_SEGMENT_DURATIONS, 1, 4'h1, 10'h0, 40'h2, 1);
    try(OP_DEFINE_SEGMENT_DURATIONS, 1, 4'h1, 10'h201, 40'h2, 1);
    try(OP_DEFINE_SEGMENT_DURATIONS, 1, 4'h1, 10'h200, 40'h1, 1);
    try(OP_DEFINE_SEGMENT_DURATIONS, 1, 4'h1, 10'h200, 40'h5f5e101, 1);
    try(OP_DEFINE_SEGMENT_DURATIONS, 1, 4'h1, 10'h200, 40'h5f5e100, 0);
    source_in = SRC_40V;
    try(OP_APPEND_SEGMENT_DURATIONS, 1, 4'h1, 10'h200, 40'h4, 1);
    try(OP_APPEND_SEGMENT_DURATIONS, 1, 4'h1, 10'h200, 40'h5, 0);
    source_in = SRC_GEN_10V;
    try(OP_APPEND_SEGMENT_DURATIONS, 1, 4'h1, 10'h200, 40'h1, 1);
    source_in = SRC_PM_10V;
    try(OP_DEFINE_SEGMENT_TRIGGER_LEVELS, 1, 4'h1, 10'h200, 40'h2, 1);
    try(OP_DEFINE_PLAYBACK_LIST, 1, 4'h1, 10'h7, 40'h1, 1);
    try(OP_APPEND_PLAYBACK_LIST, 1, 4'h1, 10'h200, 40'h0, 1);
    try(OP_APPEND_PLAYBACK_LIST, 1, 4'h1, 10'h200, LOOP_MAX + 40'h1, 1);
    try(OP_APPEND_PLAYBACK_LIST, 1, 4'h1, 10'h200, LOOP_MAX, 0);
    for (int i = 0; i < 129; i++)
      try(OP_DEFINE_SEGMENT_DURATIONS, i == 0, 4'h1, 10'h3, 40'h2, i == 128);
    try(OP_APPEND_SEGMENT_DURATIONS, 1, 4'h1, 10'h3, 40'h2, 1);
  endtask : refusals
  task automatic playback();
    try(OP_DEFINE_SEGMENT_DURATIONS, 1, 4'h1, 10'h1, 40'h2, 0);
    try(OP_DEFINE_SEGMENT_DURATIONS, 0, 4'h1, 10'h1, 40'h3, 0);
    try(OP_DEFINE_PLAYBACK_LIST, 1, 4'h1, 10'h1, 40'h2, 0);
    play(25, 20, 20);
    try(OP_DEFINE_SEGMENT_DURATIONS, 1, 4'h1, 10'h1, 40'h4, 0);
    try(OP_APPEND_SEGMENT_DURATIONS, 1, 4'h1, 10'h1, 40'h2, 0);
    try(OP_DEFINE_SEGMENT_TRIGGER_LEVELS, 1, 4'h1, 10'h1, 40'h0, 0);
    try(OP_DEFINE_PLAYBACK_LIST, 1, 4'h1, 10'h1, 40'h1, 0);
    play(17, 12, 4);
    try(OP_APPEND_PLAYBACK_LIST, 1, 4'h1, 10'h1, 40'h1, 0);
    try(OP_APPEND_SEGMENT_TRIGGER_LEVELS, 1, 4'h1, 10'h1, 40'h0, 0);
    play(29, 24, 0);
  endtask : playback
  always @(posedge clk_sys_in) begin
    cyc++;
    if (cyc == 5000) begin
      err_count++;
      complete_run();
    end
  end
  initial begin
    repeat (20) @(posedge clk_sys_in);
    #1 srst_in = 1'b0;
    chk({busy_out, seg_active_out, trig_out, done_out, cmd_error_out}, 40'h0);
    play(5, 0, 0);
    refusals();
    playback();
    complete_run();
  end
endmodule : tb_top
bind swq_segment_sequencer swq_seq_props chk_i (.clk_sys_in(clk_sys_in), .srst_in(srst_in),
  .cmd_in(cmd_in), .own_chan_in(own_chan_in), .installed_chans_in(installed_chans_in),
  .source_in(source_in), .start_in(start_in), .trig_out(trig_out),
  .seg_active_out(seg_active_out), .busy_out(busy_out), .done_out(done_out),
  .cmd_error_out(cmd_error_out));
